/* File: rtl/bpe_pkg.sv */
// constants, field layout and state type for the burst/program/erase block
// assumes a 100 MHz core clock and a 32-bit APB register bus
package bpe_pkg;
  localparam int CLK_MHZ   = 100;                 // core clock rate
  localparam int ERASE_NS  = 2000;                // modelled erase time
  localparam int ERASE_CYC = (ERASE_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_NS   = 1000;                // modelled program time
  localparam int PROG_CYC  = (PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_NS   = 500;                 // modelled page load time
  localparam int LOAD_CYC  = (LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W     = 9;                   // busy timer width

  // register byte offsets
  localparam logic [11:0] OFS_CFG  = 12'h000;     // configuration
  localparam logic [11:0] OFS_ADDR = 12'h004;     // block / buffer address
  localparam logic [11:0] OFS_CMD  = 12'h008;     // command, write only
  localparam logic [11:0] OFS_STAT = 12'h00c;     // status, read only
  localparam logic [11:0] OFS_LOCK = 12'h010;     // per-block lock mask
  localparam logic [11:0] OFS_FAIL = 12'h014;     // per-block fail inject
  localparam logic [3:0]  OFS_RAM  = 4'h1;        // paddr[11:8] of buffer

  // configuration fields
  localparam int CFG_MODE   = 0;                  // read_mode_select
  localparam int CFG_LAT    = 1;                  // latency lsb, 3 bits
  localparam int CFG_BL     = 4;                  // burst length lsb
  localparam logic [7:0] CFG_RST = 8'h08;         // async, 4 clocks, cont
  localparam logic [2:0] LAT_MIN = 3'h3;          // fewest latency clocks

  // address fields
  localparam int AD_BLK = 0;                      // target block, 4 bits
  localparam int AD_SRC = 4;                      // copy source, 4 bits
  localparam int AD_SIDX = 8;                     // buffer_sector_index
  localparam int AD_SCNT = 9;                     // buffer_sector_count_sel

  // status bits
  localparam int SB_BUSY  = 0;                    // operation_busy_flag
  localparam int SB_ERR   = 1;                    // refused operation
  localparam int SB_VFAIL = 2;                    // erase verify result
  localparam int SB_SUSP  = 3;                    // erase suspended

  // commands
  localparam logic [15:0] CMD_QERASE = 16'h0095;  // queue a block
  localparam logic [15:0] CMD_ERASE  = 16'h0094;  // erase / start queue
  localparam logic [15:0] CMD_PROG   = 16'h0080;  // program buffer
  localparam logic [15:0] CMD_CPB    = 16'h001b;  // copy-back program
  localparam logic [15:0] CMD_CPBL   = 16'h001a;  // copy-back load only
  localparam logic [15:0] CMD_SUSP   = 16'h00b0;  // erase suspend
  localparam logic [15:0] CMD_RESUME = 16'h0030;  // erase resume
  localparam logic [15:0] CMD_RST    = 16'h00f0;  // reset operation
  localparam logic [15:0] CMD_VERIFY = 16'h0071;  // erase verify read

  // burst length codes
  localparam logic [2:0] BL_4  = 3'h1;
  localparam logic [2:0] BL_8  = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_32 = 3'h4;

  typedef enum logic [2:0] {
    BPE_IDLE  = 3'h0,
    BPE_QUEUE = 3'h1,
    BPE_ERASE = 3'h3,
    BPE_SUSP  = 3'h2,
    BPE_PROG  = 3'h6,
    BPE_LOAD  = 3'h7
  } bpe_st_t;
endpackage : bpe_pkg

/* File: rtl/bpe_ctrl.sv */
// burst read, program and erase sequencer with buffer ram and small array
// assumes pins arrive unsynchronised; burst clock is sampled, not a domain
//
// Notes on behaviour
// - fixed bursts wrap within 4/8/16/32 words
// - any address may start a wrap burst
// - no 32-word burst in spare area
// - latency defaults to four clocks
// - latency programmable from three to seven
// - ready rises one clock before fetch
// - outputs off when chip/output enable high
// - load buffer, then program command runs alone
// - program ignores all commands except reset
// - host never writes the buffer being programmed
// - copy-back loads source into selected buffer
// - modify copy-back buffer only after load
// - erase sets ones; ignores all but reset/suspend
// - queue blocks with 0095h, start with 0094h
// - other command aborts pending multi erase
// - locked blocks skipped; locked final waits
// - busy from first queued address to end
// - failing block does not stop multi erase
// - verify read reports per-block pass/fail
// - start in async mode; burst needs mode bit
// - first burst word is asynchronous
module bpe_ctrl
  import bpe_pkg::*;
(
  input  wire logic        core_clk,               // core clock
  input  wire logic        rst,                    // async reset, high
  input  wire logic        psel,                   // apb select
  input  wire logic        penable,                // apb enable
  input  wire logic        pwrite,                 // apb direction
  input  wire logic [11:0] paddr,                  // apb byte address
  input  wire logic [31:0] pwdata,                 // apb write data
  output logic      [31:0] prdata,                 // apb read data
  output logic             pready,                 // apb ready
  output logic             pslverr,                // apb error
  input  wire logic        burst_clk,              // host burst clock
  input  wire logic        ce_n,                   // chip enable, low
  input  wire logic        oe_n,                   // output enable, low
  input  wire logic        address_valid_strobe_n, // address strobe, low
  input  wire logic [5:0]  addr_in,                // word address pins
  output logic      [15:0] dq_out,                 // data pins out
  output logic             dq_oe,                  // data pins enable
  output logic             rdy,                    // burst ready
  output logic             operation_busy_flag     // busy level
);
  typedef struct packed {
    bpe_st_t          st;      // sequencer state
    logic [7:0]       cfg;     // configuration
    logic [10:0]      adr;     // address register
    logic [15:0]      lock;    // lock mask
    logic [15:0]      finj;    // fail inject mask
    logic [15:0]      queue;   // blocks awaiting erase
    logic [15:0]      vfail;   // per-block erase result
    logic             vres;    // last verify result
    logic             busy;    // busy flag
    logic             err;     // refused operation
    logic             autop;   // copy-back goes on to program
    logic [TMR_W-1:0] tmr;     // busy timer
    logic [3:0]       cur;     // block being erased
    logic             pready;  // apb ready
    logic             pslverr; // apb error
    logic [31:0]      prdata;  // apb read data
    logic [9:0]       sy1;     // pin sync stage one
    logic [9:0]       sy2;     // pin sync stage two
    logic             bclk_d;  // burst clock, last sample
    logic [5:0]       baddr;   // burst word address
    logic [2:0]       lcnt;    // edges left before fetching
    logic             bact;    // burst in progress
    logic             rdy;     // ready output
    logic [15:0]      dq;      // data output
    logic             dq_oe;   // data enable output
  } bpe_state_t;

  bpe_state_t s;             // current state
  bpe_state_t next_s;        // next state

  logic [15:0] buf_ram [64]; // two 16-word buffers, then spare
  logic [15:0] flash [16][16]; // one page per block
  logic        ram_we;       // host write into buffer
  logic        prog_we;      // program finishes
  logic        ers_we;       // erase of s.cur finishes
  logic        ld_we;        // copy-back load finishes

  // lowest queued block, so the queue drains in block order
  function automatic logic [3:0] bpe_low(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
        r = 4'(i);
    end
    return r;
  endfunction : bpe_low

  // latency below three clocks is raised, unknown lengths run continuous
  function automatic logic [7:0] bpe_cfg(input logic [7:0] w);
    logic [7:0] r;
    r = w;
    if (w[CFG_LAT+:3] < LAT_MIN)
      r[CFG_LAT+:3] = LAT_MIN;
    if (w[CFG_BL+:3] > BL_32)
      r[CFG_BL+:3] = 3'h0;
    return r;
  endfunction : bpe_cfg

  // wrap mask for the next burst address
  function automatic logic [5:0] bpe_mask(input logic [2:0] bl,
                                          input logic       spare);
    logic [5:0] m;
    m = 6'h3f;
    case (bl)
      BL_4:  m = 6'h03;
      BL_8:  m = 6'h07;
      BL_16: m = 6'h0f;
      BL_32: m = spare ? 6'h0f : 6'h1f;
      default: m = 6'h3f;
    endcase
    return m;
  endfunction : bpe_mask

  // all state in one comb pass
  always_comb
  begin
    logic        acc;
    logic        cgo;
    logic [15:0] cmd;
    logic [3:0]  blk;
    logic [5:0]  ridx;
    logic [15:0] bit_b;
    logic [15:0] q;
    logic        bbusy;
    logic        edge_b;
    logic [5:0]  m;
    acc    = psel & penable & ~s.pready;
    cgo    = 1'b0;
    cmd    = pwdata[15:0];
    blk    = s.adr[AD_BLK+:4];
    ridx   = paddr[7:2];
    bit_b  = 16'h0001 << blk;
    q      = 16'h0000;
    bbusy  = (s.st == BPE_PROG) || (s.st == BPE_LOAD);
    edge_b = s.sy2[9] & ~s.bclk_d;
    m      = 6'h3f;
    next_s = s;
    ram_we  = 1'b0;
    prog_we = 1'b0;
    ers_we  = 1'b0;
    ld_we   = 1'b0;

    // pin synchronisers
    next_s.sy1 = {burst_clk, ce_n, oe_n, address_valid_strobe_n, addr_in};
    next_s.sy2 = s.sy1;
    next_s.bclk_d = s.sy2[9];

    // apb slave, answers one cycle into the access phase
    next_s.pready  = acc;
    next_s.pslverr = 1'b0;
    if (acc)
    begin
      next_s.prdata = 32'h0;
      if (paddr[11:8] == OFS_RAM)
      begin
        if (!pwrite)
          next_s.prdata = {16'h0, buf_ram[ridx]};
        else if (bbusy && !ridx[5] && ridx[4] == s.adr[AD_SIDX])
          next_s.pslverr = 1'b1;
        else
          ram_we = 1'b1;
      end
      else
      begin
        case (paddr)
          OFS_CFG:
            if (pwrite)
              next_s.cfg = bpe_cfg(pwdata[7:0]);
            else
              next_s.prdata = {24'h0, s.cfg};
          OFS_ADDR:
            if (pwrite)
              next_s.adr = pwdata[10:0];
            else
              next_s.prdata = {21'h0, s.adr};
          OFS_CMD:
            cgo = pwrite;                           // reads give zero
          OFS_STAT:
            if (pwrite)
              next_s.pslverr = 1'b1;
            else
              next_s.prdata = {28'h0, s.st == BPE_SUSP, s.vres,
                               s.err, s.busy};
          OFS_LOCK:
            if (pwrite)
              next_s.lock = pwdata[15:0];
            else
              next_s.prdata = {16'h0, s.lock};
          OFS_FAIL:
            if (pwrite)
              next_s.finj = pwdata[15:0];
            else
              next_s.prdata = {16'h0, s.finj};
          default:
            next_s.pslverr = 1'b1;                  // unmapped
        endcase
      end
    end

    // operation sequencer
    if (s.tmr != '0)
      next_s.tmr = s.tmr - 1'b1;
    unique case (s.st)
      BPE_IDLE:
        if (cgo)
        begin
          case (cmd)
            CMD_QERASE:
            begin
              if (!s.lock[blk])
                next_s.queue = bit_b;
              else
                next_s.queue = 16'h0;
              next_s.busy = 1'b1;
              next_s.st   = BPE_QUEUE;
            end
            CMD_ERASE:
              if (s.lock[blk])
                next_s.err = 1'b1;
              else
              begin
                next_s.queue = bit_b;
                next_s.cur   = blk;
                next_s.tmr   = TMR_W'(ERASE_CYC - 1);
                next_s.busy  = 1'b1;
                next_s.err   = 1'b0;
                next_s.st    = BPE_ERASE;
              end
            CMD_PROG:
              if (s.lock[blk])
                next_s.err = 1'b1;
              else
              begin
                next_s.tmr  = TMR_W'(PROG_CYC - 1);
                next_s.busy = 1'b1;
                next_s.err  = 1'b0;
                next_s.st   = BPE_PROG;
              end
            CMD_CPB, CMD_CPBL:
            begin
              next_s.autop = (cmd == CMD_CPB);
              next_s.tmr   = TMR_W'(LOAD_CYC - 1);
              next_s.busy  = 1'b1;
              next_s.err   = 1'b0;
              next_s.st    = BPE_LOAD;
            end
            CMD_VERIFY:
              next_s.vres = s.vfail[blk];
            default:
              next_s.st = BPE_IDLE;
          endcase
        end
      BPE_QUEUE:
        if (cgo)
        begin
          if (cmd == CMD_QERASE)
          begin
            if (!s.lock[blk])
              next_s.queue = s.queue | bit_b;
          end
          else if (cmd == CMD_ERASE)
          begin
            // a locked final address leaves the queue waiting
            if (!s.lock[blk])
            begin
              q = s.queue | bit_b;
              next_s.queue = q;
              next_s.cur   = bpe_low(q);
              next_s.tmr   = TMR_W'(ERASE_CYC - 1);
              next_s.st    = BPE_ERASE;
            end
          end
          else
          begin
            next_s.queue = 16'h0;
            next_s.busy  = 1'b0;
            next_s.st    = BPE_IDLE;
          end
        end
      BPE_ERASE:
        if (cgo && cmd == CMD_RST)
        begin
          next_s.queue = 16'h0;
          next_s.busy  = 1'b0;
          next_s.st    = BPE_IDLE;
        end
        else if (cgo && cmd == CMD_SUSP)
          next_s.st = BPE_SUSP;
        else if (s.tmr == '0)
        begin
          // a failed block is recorded and the queue goes on
          ers_we = ~s.finj[s.cur];
          next_s.vfail[s.cur] = s.finj[s.cur];
          q = s.queue & ~(16'h0001 << s.cur);
          next_s.queue = q;
          if (q != 16'h0)
          begin
            next_s.cur = bpe_low(q);
            next_s.tmr = TMR_W'(ERASE_CYC - 1);
          end
          else
          begin
            next_s.busy = 1'b0;
            next_s.st   = BPE_IDLE;
          end
        end
      BPE_SUSP:
        if (cgo && cmd == CMD_RST)
        begin
          next_s.queue = 16'h0;
          next_s.busy  = 1'b0;
          next_s.st    = BPE_IDLE;
        end
        else if (cgo && cmd == CMD_RESUME)
        begin
          // resume restarts the block erase from the beginning
          next_s.tmr = TMR_W'(ERASE_CYC - 1);
          next_s.st  = BPE_ERASE;
        end
      BPE_PROG:
        if (cgo && cmd == CMD_RST)
        begin
          next_s.busy = 1'b0;
          next_s.st   = BPE_IDLE;
        end
        else if (s.tmr == '0)
        begin
          prog_we     = 1'b1;
          next_s.busy = 1'b0;
          next_s.st   = BPE_IDLE;
        end
      BPE_LOAD:
        if (cgo && cmd == CMD_RST)
        begin
          next_s.busy = 1'b0;
          next_s.st   = BPE_IDLE;
        end
        else if (s.tmr == '0)
        begin
          ld_we = 1'b1;
          if (s.autop)
          begin
            next_s.tmr = TMR_W'(PROG_CYC - 1);
            next_s.st  = BPE_PROG;
          end
          else
          begin
            next_s.busy = 1'b0;
            next_s.st   = BPE_IDLE;
          end
        end
    endcase

    // burst read port
    m = bpe_mask(s.cfg[CFG_BL+:3], s.baddr[5]);
    if (s.sy2[8])
    begin
      next_s.bact = 1'b0;
      next_s.rdy  = 1'b0;
    end
    else if (!s.cfg[CFG_MODE])
    begin
      next_s.baddr = s.sy2[5:0];
      next_s.bact  = 1'b0;
      next_s.rdy   = 1'b0;
    end
    else if (!s.sy2[6])
    begin
      // first word follows the pins at once, whatever the latency
      next_s.baddr = s.sy2[5:0];
      next_s.rdy   = 1'b0;
      if (edge_b)
      begin
        next_s.lcnt = s.cfg[CFG_LAT+:3] - 3'h1;
        next_s.bact = 1'b1;
      end
    end
    else if (edge_b && s.bact)
    begin
      if (s.lcnt > 3'h1)
      begin
        next_s.lcnt = s.lcnt - 3'h1;
        next_s.rdy  = (s.lcnt == 3'h2);
      end
      else
      begin
        next_s.lcnt  = 3'h0;
        next_s.baddr = (s.baddr & ~m) | ((s.baddr + 6'h01) & m);
      end
    end
    next_s.dq    = buf_ram[next_s.baddr];
    next_s.dq_oe = ~s.sy2[8] & ~s.sy2[7];
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s       <= '0;
      s.st    <= BPE_IDLE;
      s.cfg   <= CFG_RST;
      s.sy1   <= 10'h1ff;
      s.sy2   <= 10'h1ff;
    end
    else
      s <= next_s;
  end

  // memories carry no reset; power-up contents are unknown
  always_ff @(posedge core_clk)
  begin
    if (ram_we)
      buf_ram[paddr[7:2]] <= pwdata[15:0];
    if (ld_we)
    begin
      for (int i = 0; i < 16; i++)
      begin
        if (4'(i) <= {s.adr[AD_SCNT+:2], 2'h3})
          buf_ram[{1'b0, s.adr[AD_SIDX], 4'(i)}] <=
            flash[s.adr[AD_SRC+:4]][i];
      end
    end
    if (prog_we)
    begin
      // programming only clears bits
      for (int i = 0; i < 16; i++)
        flash[s.adr[AD_BLK+:4]][i] <= flash[s.adr[AD_BLK+:4]][i] &
          buf_ram[{1'b0, s.adr[AD_SIDX], 4'(i)}];
    end
    if (ers_we)
    begin
      for (int i = 0; i < 16; i++)
        flash[s.cur][i] <= 16'hffff;
    end
  end

  assign prdata              = s.prdata;
  assign pready              = s.pready;
  assign pslverr             = s.pslverr;
  assign dq_out              = s.dq;
  assign dq_oe               = s.dq_oe;
  assign rdy                 = s.rdy;
  assign operation_busy_flag = s.busy;
endmodule : bpe_ctrl

/* File: test/bpe_ctrl_monitor.sv */
// assertions on the control block's bus, burst and busy ports
// assumes it is bound onto bpe_ctrl and sees its ports only
module bpe_ctrl_monitor
  import bpe_pkg::*;
(
  input wire logic        core_clk,           // core clock
  input wire logic        rst,                // async reset
  input wire logic        psel,               // apb select
  input wire logic        penable,            // apb enable
  input wire logic        pwrite,             // apb direction
  input wire logic [11:0] paddr,              // apb address
  input wire logic [31:0] pwdata,             // apb write data
  input wire logic        pready,             // apb ready
  input wire logic        pslverr,            // apb error
  input wire logic        ce_n,               // chip enable, low
  input wire logic        oe_n,               // output enable, low
  input wire logic        dq_oe,              // data pin enable
  input wire logic        rdy,                // burst ready
  input wire logic        operation_busy_flag // busy level
);
  timeunit 1ns;
  timeprecision 1ps;

  // one domain; nothing is judged while reset is high
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // queue command taken on the first access edge, before ready rises
  logic qcmd;
  assign qcmd = psel && penable && !pready && pwrite && paddr == OFS_CMD
                && pwdata[15:0] == CMD_QERASE;

  access_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("no ready one cycle into access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready && psel)
    else $error("error outside a finished access");
  stat_refuse_a: assert property (pready && pwrite && paddr == OFS_STAT
    |-> pslverr)
    else $error("status write not refused");
  // sync path is three flops deep, so five cycles is ample
  out_off_a: assert property ((ce_n || oe_n) [*5] |-> !dq_oe)
    else $error("data pins driven while disabled");
  out_on_a: assert property ((!ce_n && !oe_n) [*5] |-> dq_oe)
    else $error("data pins not driven while enabled");
  rdy_drop_a: assert property (ce_n [*5] |-> !rdy)
    else $error("ready stays up after deselect");
  queue_busy_a: assert property (qcmd && !operation_busy_flag
    |-> ##[1:2] operation_busy_flag)
    else $error("busy not raised by first queued block");
endmodule : bpe_ctrl_monitor

/* File: test/bpe_host.sv */
// host model on the burst pins: enables, strobe, address, link clock
// assumes the bench calls open, then tick per edge, then close
module bpe_host
(
  output logic       burst_clk, // link clock, parked between bursts
  output logic       ce_n,      // chip enable, low
  output logic       oe_n,      // output enable, low
  output logic       address_valid_strobe_n, // address strobe, low
  output logic [5:0] addr_in    // word address
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: deselected, clock low
  initial
  begin
    burst_clk = 1'b0;
    ce_n = 1'b1;
    oe_n = 1'b1;
    address_valid_strobe_n = 1'b1;
    addr_in = 6'h2a;
  end

  // one 80 ns link clock period
  task tick();
    #40 burst_clk = 1'b1;
    #40 burst_clk = 1'b0;
  endtask : tick

  // strobe the start address on one edge, then let it go
  task open(input logic [5:0] a);
    #3 ce_n = 1'b0; // keeps edges off the core clock
    oe_n = 1'b0;
    address_valid_strobe_n = 1'b0;
    addr_in = a;
    tick();
    address_valid_strobe_n = 1'b1;
    addr_in = ~a; // released pins do not hold the address
  endtask : open

  // end the burst after its last word
  task close();
    ce_n = 1'b1;
    oe_n = 1'b1;
  endtask : close
endmodule : bpe_host

/* File: test/bpe_ctrl_bench.sv */
// self-checking bench for bpe_ctrl: apb master plus burst host model
// assumes the monitor is bound below and the package is compiled first
module bpe_ctrl_bench;
  import bpe_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;   // core clock
  logic        rst = 1'b1;        // reset
  logic        psel = 1'b0;       // apb request
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;        // read data, last taken
  logic        pready, pslverr, err;
  logic        burst_clk, ce_n, oe_n, address_valid_strobe_n;
  logic [5:0]  addr_in;
  logic [15:0] dq_out;
  logic        dq_oe, rdy, busy;
  logic [15:0] mem [64];          // expected buffer words
  int          fail_count = 0, checks_done = 0;
  int          cyc = 0, seed = 53, i, t;

  bpe_ctrl dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .burst_clk(burst_clk), .ce_n(ce_n), .oe_n(oe_n),
    .address_valid_strobe_n(address_valid_strobe_n), .addr_in(addr_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .rdy(rdy),
    .operation_busy_flag(busy));
  bpe_host host (.burst_clk(burst_clk), .ce_n(ce_n), .oe_n(oe_n),
    .address_valid_strobe_n(address_valid_strobe_n), .addr_in(addr_in));

  // clock, reset and a hang limit well past the expected run
  always #5 core_clk = ~core_clk;
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done = checks_done + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // one apb transfer; holds everything until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task cmd(input logic [31:0] a, input logic [15:0] c);
    wr(OFS_ADDR, a);
    wr(OFS_CMD, {16'h0, c});
  endtask : cmd
  task bsy(input logic e);
    repeat (2) @(posedge core_clk);
    chk(32'(busy), 32'(e));
  endtask : bsy
  // cycles until busy falls, capped so a stuck flag still ends
  task waitlow();
    t = 0;
    while (busy !== 1'b0 && t < 1000)
    begin
      @(posedge core_clk);
      t = t + 1;
    end
  endtask : waitlow
  task vfy(input logic [31:0] b, input logic e);
    cmd(b, CMD_VERIFY);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd[SB_VFAIL]), 32'(e));
  endtask : vfy
  task note(input string s);
    $display("test %s done", s);
  endtask : note

  function logic [11:0] ram(input int k);
    return {OFS_RAM, 6'(k), 2'h0};
  endfunction : ram
  // k-th burst address; spare area caps the wrap at 16
  function logic [5:0] wrap(input logic [5:0] s, input int n, input int k);
    logic [5:0] m;
    m = (n == 32 && s[5]) ? 6'h0f : 6'(n - 1);
    return (s & ~m) | ((s + 6'(k)) & m);
  endfunction : wrap

  // fixed-length burst; words move only after the latency edges
  task burst(input logic [2:0] code, input logic [2:0] lat,
             input logic [5:0] s);
    int n;
    int k;
    n = 2 << code;
    wr(OFS_CFG, {25'h0, code, lat, 1'b1});
    rdchk(OFS_CFG, {25'h0, code, lat, 1'b1});
    host.open(s);
    chk(32'(dq_oe), 32'h1);
    chk(32'(dq_out), 32'(mem[s]));
    for (k = 1; k < lat + n - 1; k++)
    begin
      host.tick();
      chk(32'(rdy), 32'(k >= lat - 2));
      chk(32'(dq_out),
          32'(mem[wrap(s, n, k < lat - 1 ? 0 : k - lat + 2)]));
    end
    host.close();
    repeat (6) @(posedge core_clk);
    chk(32'(dq_oe), 32'h0);
  endtask : burst

  task finish_test();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    wait (rst == 1'b0);
    rdchk(OFS_CFG, {24'h0, CFG_RST});
    for (i = 0; i < 64; i++)
    begin
      mem[i] = 16'($random(seed));
      wr(ram(i), {16'h0, mem[i]});
    end
    for (i = 1; i < 5; i++)
      burst(3'(i), 3'(i + 2), 6'($random(seed)) & 6'h1f);
    burst(BL_32, 3'h7, 6'h20 | 6'($random(seed)));
    note("burst");
    wr(OFS_LOCK, 32'h4); // block 2 locked
    wr(OFS_FAIL, 32'h8); // block 3 fails its erase
    cmd(1, CMD_QERASE);
    bsy(1'b1);
    cmd(2, CMD_QERASE);
    cmd(3, CMD_QERASE);
    cmd(2, CMD_ERASE); // locked final: must keep waiting
    repeat (450) @(posedge core_clk);
    chk(32'(busy), 32'h1);
    cmd(4, CMD_ERASE);
    waitlow();
    chk(32'(t >= 590 && t <= 605), 32'h1);
    vfy(1, 1'b0);
    vfy(3, 1'b1);
    vfy(4, 1'b0);
    cmd(32'h40, CMD_CPBL); // four words of block 4 into buffer 0
    waitlow();
    for (i = 0; i < 4; i++)
      rdchk(ram(i), 32'hffff);
    rdchk(ram(4), {16'h0, mem[4]});
    cmd(5, CMD_QERASE);
    bsy(1'b1);
    cmd(5, CMD_RESUME);
    bsy(1'b0);
    cmd(5, CMD_ERASE); // single erase, suspended while it runs
    wr(OFS_CMD, {16'h0, CMD_SUSP});
    repeat (300) @(posedge core_clk);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd[3:0]), 32'h9); // suspended, still busy
    wr(OFS_CMD, {16'h0, CMD_RESUME});
    waitlow();
    chk(32'(t >= 195 && t <= 205), 32'h1); // erase restarts in full
    cmd(6, CMD_ERASE);
    wr(OFS_CMD, {16'h0, CMD_RST});
    bsy(1'b0); // reset ends the erase
    note("erase");
    for (i = 0; i < 16; i++)
    begin
      mem[i] = 16'($random(seed));
      wr(ram(i), {16'h0, mem[i]});
    end
    cmd(32'h604, CMD_PROG); // one page per block keeps page order
    wr(OFS_CMD, {16'h0, CMD_QERASE}); // ignored while programming
    apb(1'b1, ram(0), 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, ram(16), 32'h0);
    chk(32'(err), 32'h0);
    waitlow();
    chk(32'(t <= 100), 32'h1);
    cmd(32'h745, CMD_CPB); // block 4 via buffer 1 into block 5
    apb(1'b1, ram(17), 32'h0);
    chk(32'(err), 32'h1);
    waitlow();
    chk(32'(t >= 140 && t <= 150), 32'h1); // load, then program
    for (i = 0; i < 16; i++)
      rdchk(ram(16 + i), {16'h0, mem[i]});
    apb(1'b0, 12'h018, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, OFS_STAT, 32'h0);
    chk(32'(err), 32'h1);
    note("program");
    finish_test();
  end
endmodule : bpe_ctrl_bench

bind bpe_ctrl bpe_ctrl_monitor mon (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .dq_oe(dq_oe), .rdy(rdy),
  .operation_busy_flag(operation_busy_flag)
);
